// ---- bench/kar_ctl_model.sv ----
/* Loop controller model; the bench calls its tasks. */
`timescale 1ns/1ps
`default_nettype none
module kar_ctl_model (
    // clock
    input wire logic clk,
    // to the device
    output logic cmdValid = 1'b0,
    output logic [7:0] cmdOpcode = 8'h00,
    output logic pollPulse = 1'b0,
    // from the device
    input wire logic cmdUnsupported
);
    // opcode goes stale-inverted so a late sample cannot match
    task automatic send(input logic [7:0] o, output logic u);
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdOpcode <= o;
        @(posedge clk);
        u = cmdUnsupported;
        cmdValid <= 1'b0;
        cmdOpcode <= ~o;
    endtask
    task automatic poll(input int n);
        repeat (n) begin
            @(posedge clk);
            pollPulse <= 1'b1;
            @(posedge clk);
            pollPulse <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ---- bench/kar_key_cmd_asserts.sv ----
/* Port checker for kar_key_cmd; assumes default parameters. */
`timescale 1ns/1ps
`default_nettype none
`include "kar_regs.svh"
module kar_key_cmd_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // inputs
    input wire logic cmdValid,
    input wire logic [7:0] cmdOpcode,
    input wire logic keyEvent,
    input wire logic [7:0] keyCode,
    // outputs
    input wire logic cmdUnsupported,
    input wire logic reportValid,
    input wire logic [6:0] promptLamp,
    input wire logic [6:0] ackPulse,
    input wire logic [7:0] describeCaps,
    input wire logic repeatEnabled
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // ====
    // properties
    sequence s_cmd(o);
        cmdValid && cmdOpcode == o;
    endsequence
    property p_pr; s_cmd(`KAR_OP_PROMPT_FIRST) |=> promptLamp[0]; endproperty
    a_pr: assert property (p_pr) else $error("lamp");
    property p_ack; s_cmd(`KAR_OP_ACK_FIRST) |=> ackPulse == 7'h01; endproperty
    a_ack: assert property (p_ack) else $error("ack");
    property p_off; s_cmd(`KAR_OP_ACK_FIRST) |=> !promptLamp[0]; endproperty
    a_off: assert property (p_off) else $error("cancel");
    property p_quiet; s_cmd(`KAR_OP_ACK_LAST) |-> !cmdUnsupported; endproperty
    a_quiet: assert property (p_quiet) else $error("quiet");
    property p_dis; s_cmd(`KAR_OP_RPT_DISABLE) |=> !repeatEnabled; endproperty
    a_dis: assert property (p_dis) else $error("dis");
    property p_en; s_cmd(`KAR_OP_RPT_EN_FAST) |=> repeatEnabled; endproperty
    a_en: assert property (p_en) else $error("en");
    property p_caps; describeCaps == 8'hFF; endproperty
    a_caps: assert property (p_caps) else $error("caps");
    property p_rep;
        keyEvent && keyCode != `KAR_KEY_CURSOR_RPT |=> reportValid;
    endproperty
    a_rep: assert property (p_rep) else $error("report");
endmodule
bind kar_key_cmd kar_key_cmd_asserts i_kar_key_cmd_asserts (.clk, .rst, .cmdValid,
    .cmdOpcode, .keyEvent, .keyCode, .cmdUnsupported, .reportValid, .promptLamp, .ackPulse,
    .describeCaps, .repeatEnabled);
`default_nettype wire

// ---- bench/tb_top.sv ----
/* Bench for kar_key_cmd; assumes default parameters. */
`timescale 1ns/1ps
`default_nettype none
`include "kar_regs.svh"
module tb_top;
    logic clk = 1'b0, rst = 1'b1, reportReady = 1'b1, keyEvent = 1'b0, keyDown = 1'b0;
    logic keyIsModifier = 1'b0, keyIsCursor = 1'b0, cmdValid, pollPulse, cmdUnsupported;
    logic reportValid, genPromptPulse, genAckPulse, repeatEnabled;
    logic [7:0] keyCode = 8'h00, cmdOpcode, reportData, describeCaps;
    logic [6:0] promptLamp, ackPulse;
    logic [7:0] got[$];
    int n_errors = 0, num_checks = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (reportValid && reportReady) got.push_back(reportData);
    kar_ctl_model i_kar_ctl_model (.clk, .cmdValid, .cmdOpcode, .pollPulse, .cmdUnsupported);
    kar_key_cmd i_kar_key_cmd (.clk, .rst, .cmdValid, .cmdOpcode, .pollPulse,
        .cmdUnsupported, .keyEvent, .keyDown, .keyCode, .keyIsModifier, .keyIsCursor,
        .reportValid, .reportReady, .reportData, .promptLamp, .genPromptPulse,
        .ackPulse, .genAckPulse, .describeCaps, .repeatEnabled);
    // ====
    // helpers
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h want %h", $time, s, e);
        end
    endtask
    task automatic cmd(input logic [7:0] o);
        logic u;
        i_kar_ctl_model.send(o, u);
        chk({7'h00, u}, 8'h00);
        #1;
    endtask
    task automatic key(input logic [7:0] c, input logic d, input logic cu, input logic m);
        @(posedge clk);
        keyEvent <= 1'b1;
        keyCode <= c;
        keyDown <= d;
        keyIsCursor <= cu;
        keyIsModifier <= m;
        @(posedge clk);
        keyEvent <= 1'b0;
        keyCode <= ~c;
    endtask
    // polls, drain, then the whole report list
    task automatic reps(input int n, input logic [7:0] e[$]);
        i_kar_ctl_model.poll(n);
        repeat (4) @(posedge clk);
        chk(8'(got.size()), 8'(e.size()));
        foreach (e[i]) chk(got[i], e[i]);
        got.delete();
    endtask
    // ====
    // scenarios
    task automatic t_cmds();
        for (int n = 0; n < 7; n++) begin
            cmd(`KAR_OP_PROMPT_FIRST + 8'(n));
            chk({1'b0, promptLamp}, {1'b0, 7'h7F >> (6 - n)});
        end
        cmd(`KAR_OP_PROMPT_GEN);
        chk({7'h00, genPromptPulse}, 8'h01);
        chk(describeCaps, 8'hFF);
        for (int n = 0; n < 7; n++) begin
            cmd(`KAR_OP_ACK_FIRST + 8'(n));
            chk({1'b0, ackPulse}, {1'b0, 7'h01 << n});
            chk({1'b0, promptLamp}, {1'b0, 7'h7E << n});
        end
        cmd(`KAR_OP_ACK_GEN);
        chk({7'h00, genAckPulse}, 8'h01);
        $display("end of command test");
    endtask
    task automatic t_repeat();
        cmd(`KAR_OP_RPT_EN_SLOW);
        chk({7'h00, repeatEnabled}, 8'h01);
        key(8'h30, 1'b1, 1'b0, 1'b0);
        reps(2, '{8'h30, 8'h30});
        key(8'h50, 1'b1, 1'b1, 1'b0);
        reps(2, '{8'h50, `KAR_KEY_CURSOR_RPT});
        cmd(`KAR_OP_RPT_EN_FAST);
        reps(2, '{`KAR_KEY_CURSOR_RPT, `KAR_KEY_CURSOR_RPT});
        key(8'h50, 1'b0, 1'b1, 1'b0);
        reps(2, '{8'h50});
        key(8'h30, 1'b1, 1'b0, 1'b0);
        i_kar_ctl_model.poll(1);
        key(8'h36, 1'b1, 1'b0, 1'b0);
        reps(1, '{8'h30, 8'h36});
        key(8'h08, 1'b1, 1'b0, 1'b1);
        reps(2, '{8'h08});
        key(`KAR_KEY_CURSOR_RPT, 1'b1, 1'b0, 1'b0);
        repeat (4) @(posedge clk);
        chk(8'(got.size()), 8'h00);
        cmd(`KAR_OP_RPT_DISABLE);
        @(posedge clk);
        reportReady <= 1'b0;
        key(8'h32, 1'b1, 1'b0, 1'b0);
        key(8'h32, 1'b0, 1'b0, 1'b0);
        key(8'h34, 1'b1, 1'b0, 1'b0);
        @(posedge clk);
        reportReady <= 1'b1;
        reps(4, '{8'h32, 8'h32});
        $display("end of repeat test");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        $display("[FAIL] %0t run did not end", $time);
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_cmds();
        t_repeat();
        wrap_up();
    end
endmodule
`default_nettype wire

// ---- include/kar_pkg.sv ----
/*
 Types for the keyboard command interpreter. Assumes nothing outside.
*/
package kar_pkg;
    typedef enum logic [2:0] {
        KAR_CMD_NONE = 3'b001,
        KAR_CMD_STIM = 3'b010,
        KAR_CMD_UNSUP = 3'b100
    } kar_cmd_t;
endpackage

// ---- include/kar_regs.svh ----
/*
 Command opcodes, keycodes, a capability bit position and repeat timing for the
 keyboard command interpreter. Assumes inclusion by bare name.
*/
`ifndef KAR_REGS_SVH
`define KAR_REGS_SVH
// ==================================================
// command opcodes
`define KAR_OP_RPT_DISABLE 8'h3D
`define KAR_OP_RPT_EN_SLOW 8'h3E
`define KAR_OP_RPT_EN_FAST 8'h3F
`define KAR_OP_PROMPT_FIRST 8'hA1
`define KAR_OP_PROMPT_LAST 8'hA7
`define KAR_OP_PROMPT_GEN 8'hA8
`define KAR_OP_ACK_FIRST 8'hA9
`define KAR_OP_ACK_LAST 8'hAF
`define KAR_OP_ACK_GEN 8'hB0
// ==================================================
// keycodes and polls
`define KAR_KEY_CURSOR_RPT 8'h02
`define KAR_POLLS_NORMAL 2'h2
`define KAR_POLLS_FAST_CURSOR 2'h1
// ==================================================
// describe-record capability bits
`define KAR_DESC_GEN_PROMPT_BIT 7
`endif

// ---- include/kar_stream_if.sv ----
/*
 Valid/ready report stream between the key logic and its buffer.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface kar_stream_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- logic/kar_key_cmd.sv ----
/*
 Keyboard command interpreter: auto-repeat control, repeat generation,
 numbered and general prompt/acknowledge stimuli, describe capability bits.
 Assumes the loop controller delivers one-cycle command strobes and poll
 pulses on clk; key events come from a same-clock scanner that sends
 one-cycle events and gives a release the code of its press.
 The report stream behind the two-entry buffer may stall at will.
*/
// Function
// - repeat-disable: one report per transition only
// - repeat-enable only if repeat supported
// - normal held key repeats every second poll
// - modifier keys never repeat
// - cursor repeat: 3Eh every two, 3Fh every poll
// - normal repeat resends own down keycode
// - cursor repeat reports keycode 02h
// - supported prompts 1-7 stimulate; others unsupported
// - describe record shows prompt support
// - prompt n may link to button n
// - supported acks respond; others silently ignored
// - ack may cancel active prompt
// - keycode 02h never a physical key

`timescale 1ns/1ps
`default_nettype none
`include "kar_regs.svh"
module kar_key_cmd
    import kar_pkg::*;
#(
    parameter bit RPT_SUPPORTED = 1'b1,
    parameter logic [6:0] PROMPT_MASK = 7'h7F,
    parameter bit GEN_PROMPT_SUP = 1'b1,
    parameter logic [6:0] ACK_MASK = 7'h7F,
    parameter bit GEN_ACK_SUP = 1'b1,
    parameter bit ACK_CANCELS_PROMPT = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // commands from the loop controller
    input wire logic cmdValid,
    input wire logic [7:0] cmdOpcode,
    input wire logic pollPulse,
    // answer on each command
    output logic cmdUnsupported,
    // key events from the scanner
    input wire logic keyEvent,
    input wire logic keyDown,
    input wire logic [7:0] keyCode,
    input wire logic keyIsModifier,
    input wire logic keyIsCursor,
    // key report stream
    output logic reportValid,
    input wire logic reportReady,
    output logic [7:0] reportData,
    // user stimuli
    output logic [6:0] promptLamp,
    output logic genPromptPulse,
    output logic [6:0] ackPulse,
    output logic genAckPulse,
    // describe record capability byte
    output logic [7:0] describeCaps,
    output logic repeatEnabled
);

    // ==================================================
    // command decode
    kar_stream_if rptS ();
    wire isDis = cmdValid && cmdOpcode == `KAR_OP_RPT_DISABLE;
    wire isEnSlow = cmdValid && cmdOpcode == `KAR_OP_RPT_EN_SLOW;
    wire isEnFast = cmdValid && cmdOpcode == `KAR_OP_RPT_EN_FAST;
    wire isEn = isEnSlow || isEnFast;
    wire isPrN = cmdValid && cmdOpcode >= `KAR_OP_PROMPT_FIRST
        && cmdOpcode <= `KAR_OP_PROMPT_LAST;
    wire isAckN = cmdValid && cmdOpcode >= `KAR_OP_ACK_FIRST
        && cmdOpcode <= `KAR_OP_ACK_LAST;
    wire isPrG = cmdValid && cmdOpcode == `KAR_OP_PROMPT_GEN;
    wire isAckG = cmdValid && cmdOpcode == `KAR_OP_ACK_GEN;
    wire [2:0] prIdx = 3'(cmdOpcode - `KAR_OP_PROMPT_FIRST);
    wire [2:0] ackIdx = 3'(cmdOpcode - `KAR_OP_ACK_FIRST);
    // masks padded to eight so an out-of-range index reads a zero
    wire [7:0] prMaskX = {1'b0, PROMPT_MASK};
    wire [7:0] ackMaskX = {1'b0, ACK_MASK};
    wire prSup = isPrN && prMaskX[prIdx];
    wire ackSup = isAckN && ackMaskX[ackIdx];

    // ==================================================
    // answer classification
    wire enUnsup = isEn && !RPT_SUPPORTED;
    wire prUnsup = isPrN && !prSup;
    wire genPrUnsup = isPrG && !GEN_PROMPT_SUP;
    wire anyStim = prSup || ackSup || (isPrG && GEN_PROMPT_SUP) || (isAckG && GEN_ACK_SUP);
    kar_cmd_t cmdKind;
    always_comb begin
        cmdKind = KAR_CMD_NONE;
        if (enUnsup || prUnsup || genPrUnsup) cmdKind = KAR_CMD_UNSUP;
        else if (anyStim) cmdKind = KAR_CMD_STIM;
    end
    // unsupported acks fall to NONE: silent, no answer
    assign cmdUnsupported = (cmdKind == KAR_CMD_UNSUP);

    // ==================================================
    // capability byte
    // kept in a flop so the describe answer is a registered data output
    logic [7:0] describeCaps_ff;
    assign describeCaps = describeCaps_ff;
    always_ff @(posedge clk) begin
        describeCaps_ff <= {GEN_PROMPT_SUP, PROMPT_MASK};
    end

    // ==================================================
    // repeat mode
    // fast-cursor choice survives a disable; the next enable overwrites it
    logic rptEn_ff, fastCur_ff;
    assign repeatEnabled = rptEn_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            rptEn_ff <= 1'b0;
            fastCur_ff <= 1'b0;
        end else if (isDis) begin
            rptEn_ff <= 1'b0;
        end else if (isEn && RPT_SUPPORTED) begin
            rptEn_ff <= 1'b1;
            fastCur_ff <= isEnFast;
        end
    end

    // ==================================================
    // held key and poll counting
    logic held_ff, heldCur_ff;
    logic [7:0] heldCode_ff;
    logic [1:0] pollCnt_ff;

    // scanner events carrying the cursor-repeat code are dropped here
    wire keyOk = keyEvent && keyCode != `KAR_KEY_CURSOR_RPT;
    wire newDown = keyOk && keyDown && !keyIsModifier;
    wire release_ = keyOk && !keyDown && keyCode == heldCode_ff;
    wire otherDown = keyOk && keyDown;
    wire [1:0] period = heldCur_ff && fastCur_ff ?
        `KAR_POLLS_FAST_CURSOR : `KAR_POLLS_NORMAL;
    wire [1:0] nxt_pollCnt = pollCnt_ff + 2'h1;
    wire rptArmed = held_ff && rptEn_ff;
    wire periodHit = nxt_pollCnt >= period;
    wire rptDue = rptArmed && pollPulse && periodHit;

    always_ff @(posedge clk) begin
        if (rst) begin
            held_ff <= 1'b0;
            heldCur_ff <= 1'b0;
            heldCode_ff <= 8'h00;
            pollCnt_ff <= 2'h0;
        end else if (newDown) begin
            held_ff <= 1'b1;
            heldCur_ff <= keyIsCursor;
            heldCode_ff <= keyCode;
            pollCnt_ff <= 2'h0;
        end else if (release_ || otherDown) begin
            held_ff <= 1'b0;
            pollCnt_ff <= 2'h0;
        end else if (pollPulse && rptArmed) begin
            // counting only while enabled keeps a stale count from firing early
            // a stalled repeat slot is dropped, not queued
            pollCnt_ff <= rptDue ? 2'h0 : nxt_pollCnt;
        end
    end

    // ==================================================
    // report source: transitions win over repeats
    // with the buffer full a new report is refused and lost
    wire [7:0] rptCode = heldCur_ff ? `KAR_KEY_CURSOR_RPT : heldCode_ff;
    assign rptS.valid = keyOk || rptDue;
    assign rptS.data = keyOk ? keyCode : rptCode;
    kar_skid_buf #(.DEPTH(2)) uBuf (
        .clk(clk),
        .rst(rst),
        .inS(rptS),
        .outValid(reportValid),
        .outReady(reportReady),
        .outData(reportData)
    );

    // ==================================================
    // stimuli
    // prompt lamps latch; ack and general stimuli are one-cycle pulses
    logic [6:0] promptLamp_ff, ackPulse_ff;
    logic genPr_ff, genAck_ff;
    assign promptLamp = promptLamp_ff;
    assign ackPulse = ackPulse_ff;
    assign genPromptPulse = genPr_ff;
    assign genAckPulse = genAck_ff;
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : gStim
            // lamp n sits beside button n; linkage optional
            wire prHit = prSup && prIdx == 3'(gi);
            wire ackHit = ackSup && ackIdx == 3'(gi);
            always_ff @(posedge clk) begin
                if (rst) begin
                    promptLamp_ff[gi] <= 1'b0;
                    ackPulse_ff[gi] <= 1'b0;
                end else begin
                    ackPulse_ff[gi] <= ackHit;
                    if (prHit) promptLamp_ff[gi] <= 1'b1;
                    else if (ackHit && ACK_CANCELS_PROMPT)
                        promptLamp_ff[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            genPr_ff <= 1'b0;
            genAck_ff <= 1'b0;
        end else begin
            genPr_ff <= isPrG && GEN_PROMPT_SUP;
            genAck_ff <= isAckG && GEN_ACK_SUP;
        end
    end

endmodule
`default_nettype wire

// ---- logic/kar_skid_buf.sv ----
/*
 Two-entry report buffer; with a stalled receiver, keycodes arriving while both entries are full are lost.
 Assumes the receiver handshakes on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module kar_skid_buf #(
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // filling side
    kar_stream_if.snk inS,
    // draining side
    output logic outValid,
    input wire logic outReady,
    output logic [7:0] outData
);
    logic [7:0] mem_ff [DEPTH];
    logic rdPtr_ff, wrPtr_ff;
    logic [1:0] cnt_ff;
    wire push = inS.valid && inS.ready;
    wire pop = outValid && outReady;
    assign inS.ready = (cnt_ff != 2'(DEPTH));
    assign outValid = (cnt_ff != 2'h0);
    assign outData = mem_ff[rdPtr_ff];
    always_ff @(posedge clk) begin
        if (push) mem_ff[wrPtr_ff] <= inS.data;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            rdPtr_ff <= 1'b0;
            wrPtr_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            if (push) wrPtr_ff <= ~wrPtr_ff;
            if (pop) rdPtr_ff <= ~rdPtr_ff;
            cnt_ff <= cnt_ff + 2'(push) - 2'(pop);
        end
    end
endmodule
`default_nettype wire
